// File: core/ffsf_core.sv
// fifo status flag generation: 131,072 x 18 store with full/ir, empty/or,
// almost-full, almost-empty and half-full flags, apb access to offsets.
// assumes write and read agents on pclk; reset and strap pins asynchronous.
`timescale 1ns/10ps
`include "ffsf_cfg.svh"

module ffsf_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic master_reset_n,
	input wire logic partial_reset_n,
	input wire logic fall_through_select,
	input wire logic offset_load_n,
	input wire logic write_enable,
	input wire logic [`FFSF_DW-1:0] write_data,
	input wire logic read_enable,
	output ffsf_pkg::ffsf_word_t data_out,
	output logic full_flag_n,
	output logic input_ready_n,
	output logic empty_flag_n,
	output logic output_ready_n,
	output logic almost_full_flag_n,
	output logic almost_empty_flag_n,
	output logic half_full_flag_n
);
	import ffsf_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [`FFSF_NPINS-1:0] pin_raw;
	logic [`FFSF_NPINS-1:0] pin_lvl;
	localparam logic [`FFSF_NPINS-1:0] PIN_RST = `FFSF_PIN_RST;

	assign pin_raw = {offset_load_n, fall_through_select, partial_reset_n, master_reset_n};

	genvar gi;
	generate
		for (gi = 0; gi < `FFSF_NPINS; gi++) begin : g_pin
			ffsf_pin_sync #(.RST_VAL(PIN_RST[gi])) u_sync (
				.pclk(pclk),
				.presetn(presetn),
				.pin(pin_raw[gi]),
				.level(pin_lvl[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] r);
		reg_hit = (a == r);
	endfunction : reg_hit

	function automatic ffsf_ptr_t ptr_diff(input ffsf_ptr_t w, input ffsf_ptr_t r);
		ptr_diff = ffsf_ptr_t'(w - r);
	endfunction : ptr_diff

	function automatic ffsf_ptr_t default_off(input logic serial);
		default_off = serial ? `FFSF_OFF_SER : `FFSF_OFF_PAR;
	endfunction : default_off

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	ffsf_word_t mem [0:`FFSF_DEPTH-1];
	ffsf_state_t state_reg;
	ffsf_state_t state_next;
	logic wr_fire;
	logic rd_fire;
	logic load_out;

	always_ff @(posedge pclk) begin
		if (wr_fire) begin
			mem[state_reg.wr_ptr[`FFSF_AW-1:0]] <= write_data;
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		ffsf_ptr_t cnt_w;
		ffsf_ptr_t cnt_w_nx;
		ffsf_ptr_t cnt_r;
		ffsf_ptr_t cnt_r_nx;
		ffsf_ptr_t cnt_r_hf;
		ffsf_ptr_t full_lim;
		ffsf_ptr_t hf_lim;
		logic mem_has;
		logic mem_full;
		logic fwft;
		logic soft_prs;
		logic apb_setup;
		logic apb_wr;
		logic hit;
		state_next = state_reg;
		cnt_w = '0;
		cnt_w_nx = '0;
		cnt_r = '0;
		cnt_r_nx = '0;
		cnt_r_hf = '0;
		full_lim = '0;
		hf_lim = '0;
		mem_has = 1'b0;
		mem_full = 1'b0;
		fwft = 1'b0;
		soft_prs = 1'b0;
		apb_setup = 1'b0;
		apb_wr = 1'b0;
		hit = 1'b0;
		fwft = (state_reg.mode == FFSF_FALL_THROUGH);
		apb_setup = psel && !penable;
		apb_wr = psel && penable && pwrite;
		soft_prs = apb_wr && reg_hit(paddr, `FFSF_ADDR_CTRL) && pwdata[`FFSF_CTRL_SOFT_PRS];

		// write side sees read pointer and output valid bit two stages late
		cnt_w = ptr_diff(state_reg.wr_ptr, state_reg.rptr_s2);
		if (fwft) begin
			cnt_w = ffsf_ptr_t'(cnt_w + ffsf_ptr_t'(state_reg.ov_s2));
		end
		full_lim = fwft ? ffsf_ptr_t'(`FFSF_DEPTH + 18'h0_0001) : `FFSF_DEPTH;
		mem_full = (ptr_diff(state_reg.wr_ptr, state_reg.rptr_s2) == `FFSF_DEPTH);
		wr_fire = write_enable && !mem_full && (cnt_w < full_lim);
		cnt_w_nx = ffsf_ptr_t'(cnt_w + ffsf_ptr_t'(wr_fire));

		// read side sees write pointer two stages late
		mem_has = (state_reg.wptr_s2 != state_reg.rd_ptr);
		rd_fire = 1'b0;
		load_out = 1'b0;
		if (fwft) begin
			rd_fire = read_enable && state_reg.out_valid;
			load_out = mem_has && (!state_reg.out_valid || read_enable);
		end else begin
			rd_fire = read_enable && mem_has;
			load_out = rd_fire;
		end

		// ----------------------------------------------------------------
		// write side
		// ----------------------------------------------------------------
		if (wr_fire) begin
			state_next.wr_ptr = ffsf_ptr_t'(state_reg.wr_ptr + 18'h0_0001);
		end
		state_next.full_s1 = (cnt_w_nx >= full_lim);
		state_next.full_flag_n = !(state_reg.full_s1 && !fwft);
		state_next.input_ready_n = fwft ? state_reg.full_s1 : 1'b0;
		state_next.almost_full_flag_n =
			!(cnt_w_nx >= ffsf_ptr_t'(full_lim - state_reg.full_off));

		// ----------------------------------------------------------------
		// read side
		// ----------------------------------------------------------------
		if (load_out) begin
			state_next.dout = mem[state_reg.rd_ptr[`FFSF_AW-1:0]];
			state_next.rd_ptr = ffsf_ptr_t'(state_reg.rd_ptr + 18'h0_0001);
		end
		if (fwft) begin
			if (load_out) begin
				state_next.out_valid = 1'b1;
			end else if (read_enable && state_reg.out_valid) begin
				state_next.out_valid = 1'b0;
			end
		end else begin
			state_next.out_valid = 1'b0;
		end
		state_next.output_ready_n = fwft ? !state_next.out_valid : 1'b1;
		cnt_r_nx = ptr_diff(state_reg.wptr_s2, state_next.rd_ptr);
		state_next.empty_s1 = (cnt_r_nx == 18'h0_0000);
		state_next.empty_flag_n = fwft ? 1'b1 : !state_reg.empty_s1;
		cnt_r = ffsf_ptr_t'(cnt_r_nx + ffsf_ptr_t'(fwft && state_next.out_valid));
		state_next.almost_empty_flag_n = fwft ?
			(cnt_r > ffsf_ptr_t'(state_reg.empty_off + 18'h0_0001)) :
			(cnt_r > state_reg.empty_off);

		// ----------------------------------------------------------------
		// half full, cleared only by a read edge or a reset
		// ----------------------------------------------------------------
		hf_lim = fwft ? ffsf_ptr_t'(`FFSF_HALF + 18'h0_0001) : `FFSF_HALF;
		cnt_r_hf = ffsf_ptr_t'(ptr_diff(state_reg.wptr_s2, state_next.rd_ptr)
			+ ffsf_ptr_t'(fwft && state_next.out_valid));
		if (wr_fire && (cnt_w_nx > hf_lim)) begin
			state_next.half_full_flag_n = 1'b0;
		end else if (rd_fire && (cnt_r_hf <= hf_lim)) begin
			state_next.half_full_flag_n = 1'b1;
		end

		// ----------------------------------------------------------------
		// pointer exchange
		// ----------------------------------------------------------------
		state_next.rptr_s1 = state_reg.rd_ptr;
		state_next.rptr_s2 = state_reg.rptr_s1;
		state_next.ov_s1 = state_reg.out_valid;
		state_next.ov_s2 = state_reg.ov_s1;
		state_next.wptr_s1 = state_reg.wr_ptr;
		state_next.wptr_s2 = state_reg.wptr_s1;

		// ----------------------------------------------------------------
		// apb
		// ----------------------------------------------------------------
		hit = reg_hit(paddr, `FFSF_ADDR_CTRL) || reg_hit(paddr, `FFSF_ADDR_FULL_OFF)
			|| reg_hit(paddr, `FFSF_ADDR_EMPTY_OFF) || reg_hit(paddr, `FFSF_ADDR_STATUS)
			|| reg_hit(paddr, `FFSF_ADDR_COUNT);
		if (apb_setup) begin
			state_next.pslverr = !hit;
			state_next.prdata = 32'h0000_0000;
			case (paddr)
				`FFSF_ADDR_CTRL: begin
					state_next.prdata[`FFSF_CTRL_MODE] = fwft;
					state_next.prdata[`FFSF_CTRL_SERIAL] = state_reg.serial_ld;
				end
				`FFSF_ADDR_FULL_OFF: begin
					state_next.prdata[`FFSF_PW-1:0] = state_reg.full_off;
				end
				`FFSF_ADDR_EMPTY_OFF: begin
					state_next.prdata[`FFSF_PW-1:0] = state_reg.empty_off;
				end
				`FFSF_ADDR_STATUS: begin
					state_next.prdata[`FFSF_ST_FULL] = state_reg.full_flag_n;
					state_next.prdata[`FFSF_ST_INRDY] = state_reg.input_ready_n;
					state_next.prdata[`FFSF_ST_EMPTY] = state_reg.empty_flag_n;
					state_next.prdata[`FFSF_ST_OUTRDY] = state_reg.output_ready_n;
					state_next.prdata[`FFSF_ST_AFULL] = state_reg.almost_full_flag_n;
					state_next.prdata[`FFSF_ST_AEMPTY] = state_reg.almost_empty_flag_n;
					state_next.prdata[`FFSF_ST_HALFFULL] = state_reg.half_full_flag_n;
				end
				`FFSF_ADDR_COUNT: begin
					state_next.prdata[`FFSF_PW-1:0] = cnt_w;
				end
				default: begin
					state_next.prdata = 32'h0000_0000;
				end
			endcase
		end
		if (apb_wr && hit) begin
			if (reg_hit(paddr, `FFSF_ADDR_FULL_OFF)) begin
				state_next.full_off = pwdata[`FFSF_PW-1:0];
			end
			if (reg_hit(paddr, `FFSF_ADDR_EMPTY_OFF)) begin
				state_next.empty_off = pwdata[`FFSF_PW-1:0];
			end
		end

		// ----------------------------------------------------------------
		// resets clear occupancy
		// ----------------------------------------------------------------
		if (!pin_lvl[`FFSF_PIN_MRST] || !pin_lvl[`FFSF_PIN_PRST] || soft_prs) begin
			state_next.wr_ptr = '0;
			state_next.rd_ptr = '0;
			state_next.rptr_s1 = '0;
			state_next.rptr_s2 = '0;
			state_next.wptr_s1 = '0;
			state_next.wptr_s2 = '0;
			state_next.ov_s1 = 1'b0;
			state_next.ov_s2 = 1'b0;
			state_next.out_valid = 1'b0;
			state_next.full_s1 = 1'b0;
			state_next.full_flag_n = 1'b1;
			state_next.input_ready_n = 1'b0;
			state_next.empty_s1 = 1'b1;
			state_next.empty_flag_n = fwft ? 1'b1 : 1'b0;
			state_next.output_ready_n = 1'b1;
			state_next.almost_full_flag_n = 1'b1;
			state_next.almost_empty_flag_n = 1'b0;
			state_next.half_full_flag_n = 1'b1;
		end
		if (!pin_lvl[`FFSF_PIN_MRST]) begin
			state_next.mode = pin_lvl[`FFSF_PIN_FTS] ? FFSF_FALL_THROUGH : FFSF_STANDARD;
			state_next.serial_ld = pin_lvl[`FFSF_PIN_LOAD];
			state_next.full_off = default_off(pin_lvl[`FFSF_PIN_LOAD]);
			state_next.empty_off = default_off(pin_lvl[`FFSF_PIN_LOAD]);
			state_next.empty_flag_n = pin_lvl[`FFSF_PIN_FTS] ? 1'b1 : 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
			state_reg.full_off <= `FFSF_OFF_PAR;
			state_reg.empty_off <= `FFSF_OFF_PAR;
			state_reg.empty_s1 <= 1'b1;
			state_reg.full_flag_n <= 1'b1;
			state_reg.output_ready_n <= 1'b1;
			state_reg.almost_full_flag_n <= 1'b1;
			state_reg.half_full_flag_n <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign pready = psel && penable;
	assign prdata = state_reg.prdata;
	assign pslverr = psel && penable && state_reg.pslverr;
	assign data_out = state_reg.dout;
	assign full_flag_n = state_reg.full_flag_n;
	assign input_ready_n = state_reg.input_ready_n;
	assign empty_flag_n = state_reg.empty_flag_n;
	assign output_ready_n = state_reg.output_ready_n;
	assign almost_full_flag_n = state_reg.almost_full_flag_n;
	assign almost_empty_flag_n = state_reg.almost_empty_flag_n;
	assign half_full_flag_n = state_reg.half_full_flag_n;

endmodule : ffsf_core

// File: core/ffsf_cfg.svh
// constants of the fifo status flag block
// assumes inclusion by the package, the core and the bench
`ifndef FFSF_CFG_SVH
`define FFSF_CFG_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define FFSF_DW 18
`define FFSF_AW 17
`define FFSF_PW 18
`define FFSF_DEPTH 18'h2_0000
`define FFSF_HALF 18'h1_0000

// ----------------------------------------------------------------
// default offsets chosen by the load strap
// ----------------------------------------------------------------
`define FFSF_OFF_PAR 18'h0_007F
`define FFSF_OFF_SER 18'h0_03FF

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define FFSF_ADDR_CTRL 12'h000
`define FFSF_ADDR_FULL_OFF 12'h004
`define FFSF_ADDR_EMPTY_OFF 12'h008
`define FFSF_ADDR_STATUS 12'h00C
`define FFSF_ADDR_COUNT 12'h010

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FFSF_CTRL_MODE 0
`define FFSF_CTRL_SERIAL 1
`define FFSF_CTRL_SOFT_PRS 2
`define FFSF_ST_FULL 0
`define FFSF_ST_INRDY 1
`define FFSF_ST_EMPTY 2
`define FFSF_ST_OUTRDY 3
`define FFSF_ST_AFULL 4
`define FFSF_ST_AEMPTY 5
`define FFSF_ST_HALFFULL 6

// ----------------------------------------------------------------
// pin synchroniser
// ----------------------------------------------------------------
`define FFSF_NPINS 4
`define FFSF_PIN_MRST 0
`define FFSF_PIN_PRST 1
`define FFSF_PIN_FTS 2
`define FFSF_PIN_LOAD 3
`define FFSF_PIN_RST 4'hB

`endif

// File: core/ffsf_pkg.sv
// types of the fifo status flag block
// assumes ffsf_cfg.svh on the include path
`include "ffsf_cfg.svh"

package ffsf_pkg;

	typedef logic [`FFSF_PW-1:0] ffsf_ptr_t;
	typedef logic [`FFSF_DW-1:0] ffsf_word_t;

	typedef enum logic {FFSF_STANDARD, FFSF_FALL_THROUGH} ffsf_mode_t;

	typedef struct packed {
		ffsf_mode_t mode;
		logic serial_ld;
		ffsf_ptr_t full_off;
		ffsf_ptr_t empty_off;
		ffsf_ptr_t wr_ptr;
		ffsf_ptr_t rd_ptr;
		ffsf_ptr_t rptr_s1;
		ffsf_ptr_t rptr_s2;
		ffsf_ptr_t wptr_s1;
		ffsf_ptr_t wptr_s2;
		logic ov_s1;
		logic ov_s2;
		logic out_valid;
		ffsf_word_t dout;
		logic full_s1;
		logic full_flag_n;
		logic input_ready_n;
		logic empty_s1;
		logic empty_flag_n;
		logic output_ready_n;
		logic almost_full_flag_n;
		logic almost_empty_flag_n;
		logic half_full_flag_n;
		logic [31:0] prdata;
		logic pslverr;
	} ffsf_state_t;

endpackage : ffsf_pkg

// File: core/ffsf_pin_sync.sv
// three-stage synchroniser for one pin with agreement filter
// assumes a pin asynchronous to pclk; output moves once stages two and three agree
`timescale 1ns/10ps

module ffsf_pin_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	output logic level
);

	typedef struct packed {
		logic [2:0] stage;
		logic level;
	} ffsf_sync_t;

	ffsf_sync_t sync_reg;
	ffsf_sync_t sync_next;

	always_comb begin
		sync_next = sync_reg;
		sync_next.stage = {sync_reg.stage[1:0], pin};
		if (sync_reg.stage[1] == sync_reg.stage[2]) begin
			sync_next.level = sync_reg.stage[2];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_reg <= {{3{RST_VAL}}, RST_VAL};
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign level = sync_reg.level;

endmodule : ffsf_pin_sync

// File: tb/ffsf_agent.sv
// write and read agent at the far side of the flag block
// assumes one clock pclk shared with the block
`timescale 1ns/10ps

module ffsf_agent (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ft,
	input wire logic wr_go,
	input wire logic [17:0] wr_word,
	input wire logic rd_go,
	input wire logic full_flag_n,
	input wire logic input_ready_n,
	input wire logic empty_flag_n,
	input wire logic output_ready_n,
	output logic write_enable,
	output logic [17:0] write_data,
	output logic read_enable
);
	typedef struct packed {
		logic we;
		logic [17:0] wd;
		logic re;
		logic [1:0] gap;
	} ffsf_agent_t;
	ffsf_agent_t s_reg;
	ffsf_agent_t s_next;
	// reads spaced so a lagging flag is seen before the next one
	always_comb begin
		s_next = s_reg;
		s_next.we = wr_go && full_flag_n && !input_ready_n;
		s_next.wd = wr_go ? wr_word : ~s_reg.wd;
		s_next.re = 1'b0;
		if (s_reg.gap != 2'h0) s_next.gap = s_reg.gap - 2'h1;
		if (s_reg.re) s_next.gap = 2'h3;
		else if (s_reg.gap == 2'h0) s_next.re = rd_go && (ft ? !output_ready_n : empty_flag_n);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) s_reg <= '0;
		else s_reg <= s_next;
	end
	assign write_enable = s_reg.we;
	assign write_data = s_reg.wd;
	assign read_enable = s_reg.re;
endmodule : ffsf_agent

// File: tb/ffsf_props.sv
// checker of the fifo status flags, bound to ffsf_core
// assumes one clock pclk and pin resets active low
`timescale 1ns/10ps

module ffsf_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic master_reset_n,
	input wire logic partial_reset_n,
	input wire logic write_enable,
	input wire logic read_enable,
	input wire ffsf_pkg::ffsf_word_t data_out,
	input wire logic full_flag_n,
	input wire logic empty_flag_n,
	input wire logic output_ready_n,
	input wire logic almost_full_flag_n,
	input wire logic almost_empty_flag_n,
	input wire logic half_full_flag_n
);
	import ffsf_pkg::*;
	typedef struct packed {
		logic [5:0] wh;
		logic [5:0] rh;
		logic [3:0] quiet;
	} ffsf_hist_t;
	ffsf_hist_t h_reg;
	ffsf_hist_t h_next;
	logic ok;
	// recent writes and reads, cycles since pin resets
	always_comb begin
		h_next.wh = {h_reg.wh[4:0], write_enable};
		h_next.rh = {h_reg.rh[4:0], read_enable};
		h_next.quiet = h_reg.quiet + {3'h0, h_reg.quiet != 4'hF};
		if (!(master_reset_n && partial_reset_n)) h_next.quiet = 4'h0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) h_reg <= '0;
		else h_reg <= h_next;
	end
	assign ok = h_reg.quiet == 4'hF;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_full_fall; ok && $fell(full_flag_n) |-> $past(write_enable); endproperty
	a_full_fall: assert property (p_full_fall) else $error("full without write");
	property p_or_fall; ok && $fell(output_ready_n) |-> |h_reg.wh; endproperty
	a_or_fall: assert property (p_or_fall) else $error("ready without write");
	property p_or_rise; ok && $rose(output_ready_n) |-> $past(read_enable) && $stable(data_out); endproperty
	a_or_rise: assert property (p_or_rise) else $error("ready lost badly");
	property p_ef_rise; ok && $rose(empty_flag_n) |-> |h_reg.wh; endproperty
	a_ef_rise: assert property (p_ef_rise) else $error("data without write");
	property p_hf_fall; ok && $fell(half_full_flag_n) |-> |h_reg.wh[1:0]; endproperty
	a_hf_fall: assert property (p_hf_fall) else $error("half set without write");
	property p_hf_rise; ok && $rose(half_full_flag_n) |-> |h_reg.rh; endproperty
	a_hf_rise: assert property (p_hf_rise) else $error("half clear without read");
	property p_pae_fall; ok && $fell(almost_empty_flag_n) |-> |h_reg.rh; endproperty
	a_pae_fall: assert property (p_pae_fall) else $error("almost empty without read");
	property p_paf_fall; ok && $fell(almost_full_flag_n) |-> |h_reg.wh[2:0]; endproperty
	a_paf_fall: assert property (p_paf_fall) else $error("almost full without write");
endmodule : ffsf_props

bind ffsf_core ffsf_props i_ffsf_props (.pclk(pclk), .presetn(presetn),
	.master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n),
	.write_enable(write_enable), .read_enable(read_enable), .data_out(data_out),
	.full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n), .output_ready_n(output_ready_n),
	.almost_full_flag_n(almost_full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
	.half_full_flag_n(half_full_flag_n));

// File: tb/fifo_status_flag_generation_tb.sv
// bench of the fifo status flags with a queue model of the store
// assumes ffsf_core, ffsf_agent and ffsf_props compiled before it
`timescale 1ns/10ps
`include "ffsf_cfg.svh"

module fifo_status_flag_generation_tb;
	import ffsf_pkg::*;
	localparam int D = `FFSF_DEPTH;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, seed;
	logic master_reset_n, partial_reset_n, fall_through_select, offset_load_n;
	logic write_enable, read_enable, wr_go, rd_go, ft;
	logic [17:0] write_data, wr_word;
	ffsf_word_t data_out;
	logic full_flag_n, input_ready_n, empty_flag_n, output_ready_n;
	logic almost_full_flag_n, almost_empty_flag_n, half_full_flag_n;
	logic [17:0] q[$];
	int bad_count, n_compared, m, n;
	ffsf_core i_ffsf_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n),
		.fall_through_select(fall_through_select), .offset_load_n(offset_load_n),
		.write_enable(write_enable), .write_data(write_data), .read_enable(read_enable),
		.data_out(data_out), .full_flag_n(full_flag_n), .input_ready_n(input_ready_n),
		.empty_flag_n(empty_flag_n), .output_ready_n(output_ready_n),
		.almost_full_flag_n(almost_full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
		.half_full_flag_n(half_full_flag_n));
	ffsf_agent i_ffsf_agent (.pclk(pclk), .presetn(presetn), .ft(ft), .wr_go(wr_go),
		.wr_word(wr_word), .rd_go(rd_go), .full_flag_n(full_flag_n),
		.input_ready_n(input_ready_n), .empty_flag_n(empty_flag_n),
		.output_ready_n(output_ready_n), .write_enable(write_enable),
		.write_data(write_data), .read_enable(read_enable));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	// flag levels expected from the stored count, status bit order
	function automatic logic [6:0] flags(input int c);
		int f;
		f = ft;
		return {c <= D / 2 + f, c > n + f, c < D + f - m, !f || c == 0, f || c != 0, f && c > D, f || c < D};
	endfunction : flags
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict
	task automatic tmo;
		bad_count++;
		$display("MISMATCH %0t wait ran out", $time);
		give_verdict();
	endtask : tmo
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16) tmo();
		@(posedge pclk);
	endtask : apb
	task automatic rr(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(r, x);
		chk(32'(e), 32'(xe));
	endtask : rr
	task automatic wreg(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wreg
	task automatic cf;
		chk(32'({half_full_flag_n, almost_empty_flag_n, almost_full_flag_n, output_ready_n,
			empty_flag_n, input_ready_n, full_flag_n}), 32'(flags(q.size())));
		rr(`FFSF_ADDR_STATUS, 32'(flags(q.size())), 1'b0);
		rr(`FFSF_ADDR_COUNT, q.size(), 1'b0);
	endtask : cf
	task automatic mreset(input logic f, input logic l);
		master_reset_n <= 1'b0;
		fall_through_select <= f;
		offset_load_n <= l;
		repeat (8) @(posedge pclk);
		master_reset_n <= 1'b1;
		repeat (8) @(posedge pclk);
		q.delete();
		ft <= f;
		m = l ? 1023 : 127;
		n = m;
	endtask : mreset
	task automatic wr(input int k);
		for (int i = 0; i < k; i++) begin
			seed = xs(seed);
			wr_go <= 1'b1;
			wr_word <= seed[17:0];
			@(posedge pclk);
		end
		wr_go <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask : wr
	task automatic rd(input int k);
		int got;
		got = 0;
		rd_go <= 1'b1;
		for (int i = 0; i < 8 * k + 20 && got < k; i++) begin
			@(posedge pclk);
			if (read_enable === 1'b1) got++;
		end
		rd_go <= 1'b0;
		if (got < k) tmo();
		repeat (8) @(posedge pclk);
	endtask : rd
	// model store follows every accepted write and read
	always @(posedge pclk) begin
		if (write_enable === 1'b1) q.push_back(write_data);
		if (read_enable === 1'b1) begin
			if (!ft) #1;
			chk(32'(data_out), 32'(q.pop_front()));
		end
	end
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, wr_go, rd_go, ft} = '0;
		{paddr, pwdata, wr_word} = '0;
		{master_reset_n, fall_through_select, offset_load_n} = 3'b000;
		partial_reset_n = 1'b1;
		seed = 32'h0000_DF31;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		mreset(1'b0, 1'b0);
		rr(`FFSF_ADDR_CTRL, 32'h0000_0000, 1'b0);
		rr(`FFSF_ADDR_FULL_OFF, 32'h0000_007F, 1'b0);
		rr(12'h020, 32'h0000_0000, 1'b1);
		wreg(`FFSF_ADDR_FULL_OFF, 32'h0001_0000);
		wreg(`FFSF_ADDR_EMPTY_OFF, 32'h0000_0004);
		m = 65536;
		n = 4;
		rr(`FFSF_ADDR_EMPTY_OFF, 32'h0000_0004, 1'b0);
		cf();
		wr(5);
		cf();
		rd(1);
		cf();
		rd(4);
		cf();
		wr(3);
		cf();
		wreg(`FFSF_ADDR_CTRL, 32'h0000_0004);
		q.delete();
		cf();
		wr(2);
		partial_reset_n <= 1'b0;
		repeat (8) @(posedge pclk);
		partial_reset_n <= 1'b1;
		repeat (8) @(posedge pclk);
		q.delete();
		cf();
		rr(`FFSF_ADDR_EMPTY_OFF, 32'h0000_0004, 1'b0);
		wr(65535);
		cf();
		wr(1);
		cf();
		wr(1);
		cf();
		rd(1);
		cf();
		mreset(1'b1, 1'b1);
		rr(`FFSF_ADDR_CTRL, 32'h0000_0003, 1'b0);
		rr(`FFSF_ADDR_EMPTY_OFF, 32'h0000_03FF, 1'b0);
		wreg(`FFSF_ADDR_EMPTY_OFF, 32'h0000_0002);
		n = 2;
		cf();
		wr(1);
		cf();
		wr(3);
		cf();
		rd(4);
		cf();
		give_verdict();
	end
endmodule : fifo_status_flag_generation_tb
